// ---- fbx_cfg.svh ----
// timing and layout constants for the fieldbus slave buffer exchange
`ifndef FBX_CFG_SVH
`define FBX_CFG_SVH
`define FBX_CLK_NS 25
`define FBX_REFRESH_NS 3000000
`define FBX_REFRESH_CYC (`FBX_REFRESH_NS / `FBX_CLK_NS)
`define FBX_ADDR_MIN 7'h01
`define FBX_ADDR_MAX 7'h7D
`define FBX_MAX_BAUD 12000000
`endif

// ---- fbx_pkg.sv ----
// types for the fieldbus slave buffer exchange
package fbx_pkg;
    typedef enum logic [1:0] {
        FBX_WAIT_PRM = 2'b00,
        FBX_WAIT_CFG = 2'b01,
        FBX_DATA_EXCH = 2'b11
    } fbx_phase_t;
endpackage : fbx_pkg

// ---- fbx_core.sv ----
// fieldbus slave buffer exchange core: phases, send and receive buffers
// Overview of operation
// - answer only when addressed by master request
// - parameterize, then configure, then exchange data
// - exchange: outputs in, latest inputs out
// - backplane cycle gathers inputs, drives outputs
// - after backplane cycle copy images and buffers
// - fieldbus exchange fills receive, replies send
// - fieldbus cycle independent, buffers only coupling
// - backplane cycle not longer than fieldbus
// - backplane refresh at least every 3ms
// - word bytes never mixed across updates
// - station address unique within 1 to 125
// - link rate up to 12 Mbaud
`timescale 1ns/1ps
`include "fbx_cfg.svh"
module fbx_core
    import fbx_pkg::*;
#(
    parameter int NBYTES = 8,
    parameter int REFRESH_CYC = `FBX_REFRESH_CYC
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [6:0] station_addr_i,
    // fieldbus side, one telegram per strobe, same clock
    // telegrams arrive decoded, one per strobe, so even a 12 Mbaud link
    // leaves many core clocks between strobes
    input wire logic fb_req_i,
    input wire logic [6:0] fb_addr_i,
    input wire logic fb_prm_i,
    input wire logic fb_cfg_i,
    input wire logic fb_cfg_ok_i,
    input wire logic fb_exch_i,
    input wire logic [NBYTES*8-1:0] fb_out_data_i,
    output logic fb_ack_o,
    output logic [NBYTES*8-1:0] fb_in_data_o,
    // backplane side
    input wire logic bp_done_i,
    input wire logic [NBYTES*8-1:0] bp_inputs_i,
    output logic [NBYTES*8-1:0] input_process_image_o,
    output logic [NBYTES*8-1:0] output_process_image_o,
    output logic [7:0] status_o,
    output logic refresh_late_o,
    output logic data_exchange_state_o
);
    localparam int W = NBYTES * 8;
    localparam int CW = $clog2(REFRESH_CYC + 1);

    // legal station range; used by the match logic, status and checks
    function automatic logic addr_valid(input logic [6:0] a);
        addr_valid = (a >= `FBX_ADDR_MIN) && (a <= `FBX_ADDR_MAX);
    endfunction : addr_valid

    fbx_phase_t phase, next_phase;
    logic [W-1:0] send_buf, next_send_buf;
    logic [W-1:0] recv_buf, next_recv_buf;
    logic [W-1:0] in_img, next_in_img;
    logic [W-1:0] out_img, next_out_img;
    logic [W-1:0] reply, next_reply;
    logic ack, next_ack;
    logic [CW-1:0] age, next_age;
    logic late, next_late;
    logic [6:0] addr_meta;
    logic [6:0] own_addr;
    logic addr_ok;
    logic hit;
    logic take;

    // the address switch is a pin, so it passes two flops first; these
    // flops have no reset so the address is settled when reset lets go
    always_ff @(posedge mclk_i)
    begin
        addr_meta <= station_addr_i;
        own_addr <= addr_meta;
    end
    assign addr_ok = addr_valid(own_addr);

    // addressed only when our own address is legal and matches; a slave
    // never speaks unless a master asks it by name
    assign hit = fb_req_i && addr_ok
        && (fb_addr_i == own_addr);
    // exchange telegrams outside the exchange phase are answered but
    // their data is dropped
    assign take = hit && (phase == FBX_DATA_EXCH) && fb_exch_i
        && !fb_prm_i;

    // phase sequencer
    always_comb
    begin
        next_phase = phase;
        if (hit)
        begin
            unique case (phase)
                FBX_WAIT_PRM:
                    if (fb_prm_i)
                        next_phase = FBX_WAIT_CFG;
                FBX_WAIT_CFG:
                    if (fb_cfg_i)
                        next_phase = fb_cfg_ok_i ? FBX_DATA_EXCH
                            : FBX_WAIT_PRM;
                FBX_DATA_EXCH:
                    // a new parameter set forces a fresh configuration
                    if (fb_prm_i)
                        next_phase = FBX_WAIT_CFG;
                default:
                    next_phase = FBX_WAIT_PRM;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            phase <= FBX_WAIT_PRM;
        else
            phase <= next_phase;
    end

    // fieldbus side: receive buffer and reply register
    always_comb
    begin
        next_ack = hit;
        next_recv_buf = recv_buf;
        next_reply = reply;
        if (take)
        begin
            // whole words move together, never byte by byte
            next_recv_buf = fb_out_data_i;
            next_reply = send_buf;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            recv_buf <= '0;
            reply <= '0;
        end
        else
        begin
            ack <= next_ack;
            recv_buf <= next_recv_buf;
            reply <= next_reply;
        end
    end

    // backplane side: images and send buffer; the fieldbus group only
    // reads send_buf and this group only reads recv_buf, so the buffers
    // are the sole coupling between the two cycles
    always_comb
    begin
        next_in_img = in_img;
        next_out_img = out_img;
        next_send_buf = send_buf;
        if (bp_done_i)
        begin
            // both copies in one edge so neither side sees half a buffer
            next_in_img = bp_inputs_i;
            next_send_buf = bp_inputs_i;
            next_out_img = recv_buf;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            in_img <= '0;
            out_img <= '0;
            send_buf <= '0;
        end
        else
        begin
            in_img <= next_in_img;
            out_img <= next_out_img;
            send_buf <= next_send_buf;
        end
    end

    // refresh watchdog: counts clocks since the last backplane copy and
    // saturates, so a long stall cannot wrap back to a quiet value
    always_comb
    begin
        next_age = age;
        next_late = late;
        if (bp_done_i)
        begin
            next_age = '0;
            next_late = 1'b0;
        end
        else if (age < CW'(REFRESH_CYC))
            next_age = age + CW'(1);
        else
            next_late = 1'b1;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            age <= '0;
            late <= 1'b0;
        end
        else
        begin
            age <= next_age;
            late <= next_late;
        end
    end

    assign fb_ack_o = ack;
    assign fb_in_data_o = reply;
    assign input_process_image_o = in_img;
    assign output_process_image_o = out_img;
    assign refresh_late_o = late;
    assign data_exchange_state_o = (phase == FBX_DATA_EXCH);
    // status area kept apart from the data areas
    assign status_o = {4'h0, late, addr_ok, phase};

    // addressing and answers
    ack_cause_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        fb_ack_o |-> $past(hit))
        else $error("ack without addressed request");
    foreign_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        fb_req_i && fb_addr_i != own_addr |=> !fb_ack_o)
        else $error("answered a telegram for another station");
    quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !fb_req_i |=> !fb_ack_o)
        else $error("answered without a request");
    bad_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !addr_ok |=> !fb_ack_o)
        else $error("answered with illegal station address");

    // phase sequence
    no_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(phase) == FBX_WAIT_PRM |-> phase != FBX_DATA_EXCH)
        else $error("data exchange entered before configuration");
    cfg_fail_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_WAIT_CFG && fb_cfg_i && !fb_cfg_ok_i
        |=> phase == FBX_WAIT_PRM)
        else $error("failed configuration did not restart");
    cfg_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_WAIT_CFG && fb_cfg_i && fb_cfg_ok_i
        |=> phase == FBX_DATA_EXCH)
        else $error("good configuration did not open exchange");
    prm_back_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_DATA_EXCH && fb_prm_i
        |=> phase == FBX_WAIT_CFG)
        else $error("parameters in exchange did not force configuration");
    idle_phase_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !hit |=> $stable(phase))
        else $error("phase moved without an addressed telegram");

    // fieldbus buffers
    recv_take_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_DATA_EXCH && fb_exch_i && !fb_prm_i
        |=> recv_buf == $past(fb_out_data_i))
        else $error("receive buffer not loaded");
    reply_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_DATA_EXCH && fb_exch_i && !fb_prm_i
        |=> fb_in_data_o == $past(send_buf))
        else $error("reply not taken from send buffer");
    reply_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !take |=> $stable(fb_in_data_o))
        else $error("reply changed outside an exchange");
    recv_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !take |=> $stable(recv_buf))
        else $error("receive buffer changed outside an exchange");

    // backplane copies
    copy_both_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        bp_done_i |=> send_buf == $past(bp_inputs_i)
        && out_img == $past(recv_buf))
        else $error("backplane copy incomplete");
    out_img_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !bp_done_i |=> $stable(out_img))
        else $error("output image changed outside copy");
    send_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !bp_done_i |=> $stable(send_buf))
        else $error("send buffer changed outside copy");
    in_img_take_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        bp_done_i |=> input_process_image_o == $past(bp_inputs_i))
        else $error("input image not gathered");
    in_img_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !bp_done_i |=> $stable(input_process_image_o))
        else $error("input image changed outside copy");

    // refresh watchdog
    late_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        refresh_late_o |-> age == CW'(REFRESH_CYC))
        else $error("late flag before refresh limit");
    late_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        bp_done_i |=> !refresh_late_o)
        else $error("late flag kept after a copy");
    late_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !bp_done_i && age == CW'(REFRESH_CYC) |=> refresh_late_o)
        else $error("late flag missing at refresh limit");

    cov_exch_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        data_exchange_state_o && fb_ack_o);
    cov_cfg_fail_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        hit && phase == FBX_WAIT_CFG && fb_cfg_i && !fb_cfg_ok_i);
    cov_late_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        $rose(refresh_late_o));
    cov_both_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        bp_done_i && hit && fb_exch_i);
    cov_bad_addr_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        fb_req_i && !addr_ok);
endmodule : fbx_core

// ---- fbx_master.sv ----
// fieldbus master model: one telegram per call
`timescale 1ns/1ps
module fbx_master (
    input wire logic mclk_i,
    output logic req_o,
    output logic [6:0] addr_o,
    output logic prm_o,
    output logic cfg_o,
    output logic cfg_ok_o,
    output logic exch_o,
    output logic [63:0] data_o
);
    initial
    begin
        {req_o, prm_o, cfg_o, cfg_ok_o, exch_o} = 5'h00;
        addr_o = 7'h00;
        data_o = 64'h0;
    end
    // token assumed held for one telegram, passed on when it ends
    task automatic tel(input logic [6:0] a, input logic [2:0] k,
        input logic ok, input logic [63:0] d);
    begin
        @(posedge mclk_i);
        #1;
        req_o = 1'h1;
        addr_o = a;
        {prm_o, cfg_o, exch_o} = k;
        cfg_ok_o = ok;
        data_o = d;
        @(posedge mclk_i);
        #1;
        {req_o, prm_o, cfg_o, cfg_ok_o, exch_o} = 5'h00;
        // released address and data lines flip so a stale value cannot pass for a live one
        addr_o = ~a;
        data_o = ~d;
    end
    endtask : tel
endmodule : fbx_master

// ---- test_fbx_core.sv ----
// self-checking bench for the buffer exchange core
`timescale 1ns/1ps
module test_fbx_core;
    localparam int REF = 20;
    logic mclk_i = 1'h0, rst_i = 1'h1, bp_done_i = 1'h0;
    logic [6:0] own = 7'h05, fa;
    logic req, prm, cfg, ok, exch, ack, late, dxs;
    logic [63:0] fo, fi, ipi, opi, bin = 64'h0, snd = 64'h0, rcv = 64'h0;
    logic [7:0] st;
    logic [15:0] lf = 16'h24F1;
    int miscompares = 0, tests_run = 0, ph = 0;
    fbx_master m (.mclk_i(mclk_i), .req_o(req), .addr_o(fa), .prm_o(prm),
        .cfg_o(cfg), .cfg_ok_o(ok), .exch_o(exch), .data_o(fo));
    fbx_core #(.NBYTES(8), .REFRESH_CYC(REF)) dut (.mclk_i(mclk_i),
        .rst_i(rst_i), .station_addr_i(own), .fb_req_i(req), .fb_addr_i(fa),
        .fb_prm_i(prm), .fb_cfg_i(cfg), .fb_cfg_ok_i(ok), .fb_exch_i(exch),
        .fb_out_data_i(fo), .fb_ack_o(ack), .fb_in_data_o(fi),
        .bp_done_i(bp_done_i), .bp_inputs_i(bin), .status_o(st),
        .input_process_image_o(ipi), .output_process_image_o(opi),
        .refresh_late_o(late), .data_exchange_state_o(dxs));
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    end
    endtask : chk
    task automatic tx(input logic [6:0] a, input logic [2:0] k,
        input logic c, input logic [63:0] d);
        logic want;
    begin
        want = (a == own) && (own >= 7'h01) && (own <= 7'h7D);
        m.tel(a, k, c, d);
        chk(64'(ack), 64'(want));
        if (want)
        begin
            if (k == 3'h4)
                ph = 1;
            if (k == 3'h2 && ph == 1)
                ph = c ? 3 : 0;
            if (k == 3'h1 && ph == 3)
            begin
                chk(fi, snd);
                rcv = d;
            end
            chk(64'(st[1:0]), 64'(ph));
            chk(64'(dxs), 64'(ph == 3));
        end
    end
    endtask : tx
    task automatic bp(input logic [63:0] d);
    begin
        @(posedge mclk_i);
        #1;
        bp_done_i = 1'h1;
        bin = d;
        @(posedge mclk_i);
        #1;
        bp_done_i = 1'h0;
        bin = ~d;
        chk(ipi, d);
        chk(opi, rcv);
        chk(64'(late), 64'h0);
        snd = d;
    end
    endtask : bp
    task automatic wrap_up;
    begin
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : wrap_up
    initial
    begin
        repeat (2) @(posedge mclk_i);
        #1;
        rst_i = 1'h0;
        chk(64'(st), 64'h04);
        tx(own, 3'h1, 1'h0, 64'h1234);
        tx(7'h06, 3'h4, 1'h0, 64'h0);
        tx(own, 3'h4, 1'h0, 64'h0);
        tx(own, 3'h2, 1'h0, 64'h0);
        tx(own, 3'h4, 1'h0, 64'h0);
        tx(own, 3'h2, 1'h1, 64'h0);
        $display("phase test done");
        own = 7'h7E;
        repeat (2) @(posedge mclk_i);
        tx(7'h7E, 3'h4, 1'h0, 64'h0);
        chk(64'(st[2]), 64'h0);
        own = 7'h05;
        repeat (2) @(posedge mclk_i);
        $display("address test done");
        for (int i = 0; i < 6; i++)
        begin
            repeat (REF - 4) @(posedge mclk_i);
            lf = lfsr(lf);
            bp({4{lf}});
            lf = lfsr(lf);
            tx(own, 3'h1, 1'h0, {lf, ~lf, lf, 16'h0F0F});
        end
        bp(64'h0);
        $display("exchange test done");
        repeat (REF - 2) @(posedge mclk_i);
        #1;
        chk(64'(late), 64'h0);
        repeat (3) @(posedge mclk_i);
        #1;
        chk(64'(late), 64'h1);
        bp(64'h5A);
        $display("refresh test done");
        wrap_up();
    end
    initial
    begin
        #20000;
        miscompares++;
        wrap_up();
    end
endmodule : test_fbx_core
